// *** src/bcsr_regs.sv ***
// Purpose: command and primary status registers of a bridge header, apb slave
// Assumes: event inputs are one-cycle pulses from logic on pclk
// Notes:   one wait state on every apb access; unmapped words read zero with pslverr
//
// Overview of operation
// - command bit 0 clear ignores primary io
// - command bit 1 clear ignores primary memory
// - bit 2 clear blocks mastering and forwarding
// - command bit 3 reads zero, read-only
// - command bit 4 reads zero, read-only
// - bit 6 lets parity faults set bit 24
// - bit 8 gates sending error messages
// - bit 10 keeps inta_assert deasserted; irq is not gated by it
// - bits 5, 7, 9, 15:11 read zero
// - status bit 20 reads one, pointer 34h
// - status bits 21, 23, 26:25 read zero
// - bit 24 set only with parity response
// - bit 27 set on completer abort sent
// - bit 28 set on completer abort received
// - bit 29 set on unsupported request received
// - bit 30 set on error message sent
// - bit 31 set on any poisoned packet received
// - flags clear only by writing one
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module bcsr_regs
   import bcsr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire logic              io_req,
   input  wire logic              mem_rd_req,
   input  wire logic              fwd_req,
   input  wire logic              poison_cpl_rx,
   input  wire logic              poison_wr_tx,
   input  wire logic              parity_err,
   input  wire logic              poison_tlp_rx,
   input  wire logic              cpl_abort_tx,
   input  wire logic              cpl_abort_rx,
   input  wire logic              cpl_ur_rx,
   input  wire logic              err_msg_req,
   input  wire logic              intx_req,
   output logic                   io_accept,
   output logic                   mem_rd_accept,
   output logic                   fwd_accept,
   output logic                   err_msg_send,
   output logic                   inta_assert,
   output logic                   irq
);

   // elaboration check: the decoded offsets must fit the address
   if (ADDR_W < 7 || ADDR_W > 12) begin : g_bad_addr_w
      $error("bcsr_regs: ADDR_W must be 7..12");
   end

   // word select, shared by read and write decode
   function automatic logic bcsr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      bcsr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   logic [15:0] cmd_reg;
   logic [15:0] stat_reg;
   logic [15:0] stat_next;
   logic [15:0] stat_set;
   logic [15:0] stat_clr;
   logic [5:0]  irq_stat_reg;
   logic [5:0]  irq_stat_next;
   logic [5:0]  irq_mask_reg;
   logic [5:0]  irq_mask_next;
   logic [5:0]  irq_ev;
   logic [5:0]  irq_clr;
   logic        wr_done;
   logic        acc_phase;
   logic        hit_cs;
   logic        hit_is;
   logic        hit_im;
   logic        mapped;
   logic        err_send;
   logic [31:0] rd_word;

   // apb decode; a write lands only at the edge that completes the access
   assign acc_phase = psel && penable;
   assign wr_done   = acc_phase && pready && pwrite;
   assign hit_cs    = bcsr_hit(paddr, BCSR_OFF_CMD_STAT);
   assign hit_is    = bcsr_hit(paddr, BCSR_OFF_IRQ_STAT);
   assign hit_im    = bcsr_hit(paddr, BCSR_OFF_IRQ_MASK);
   assign mapped    = hit_cs || hit_is || hit_im;

   // handshake: one wait state, then pready for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc_phase && !pready;
         pslverr <= acc_phase && !pready && !mapped;
      end
   end

   // read mux; reserved and unsupported bits come back zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_cs) begin
         rd_word = {stat_reg | BCSR_ST_CONST, cmd_reg};
      end else if (hit_is) begin
         rd_word = {26'h0, irq_stat_reg};
      end else if (hit_im) begin
         rd_word = {26'h0, irq_mask_reg};
      end
   end

   // read data register, loaded with the answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (acc_phase && !pready && !pwrite) begin
         prdata <= rd_word;
      end
   end

   // command register: only the writable bits take data, byte enables honoured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_reg <= BCSR_CMD_RESET;
      end else if (wr_done && hit_cs) begin
         if (pstrb[0]) begin
            cmd_reg[7:0]  <= pwdata[7:0] & BCSR_CMD_WMASK[7:0];
         end
         if (pstrb[1]) begin
            cmd_reg[15:8] <= pwdata[15:8] & BCSR_CMD_WMASK[15:8];
         end
      end
   end

   // error message goes out only while reporting is enabled
   assign err_send = err_msg_req && cmd_reg[BCSR_CMD_SERR_EN];

   // status flag set terms
   always_comb begin
      stat_set                     = 16'h0000;
      stat_set[BCSR_ST_MDPE]       = cmd_reg[BCSR_CMD_PAR_RESP]
                                     && (poison_cpl_rx || poison_wr_tx || parity_err);
      stat_set[BCSR_ST_SIG_TABORT] = cpl_abort_tx;
      stat_set[BCSR_ST_RCV_TABORT] = cpl_abort_rx;
      stat_set[BCSR_ST_RCV_MABORT] = cpl_ur_rx;
      stat_set[BCSR_ST_SIG_SERR]   = err_send;
      stat_set[BCSR_ST_DET_PERR]   = poison_tlp_rx || poison_cpl_rx;
   end

   // write-one-to-clear on the status half, set beats clear
   always_comb begin
      stat_clr = 16'h0000;
      if (wr_done && hit_cs) begin
         stat_clr = {pstrb[3] ? pwdata[31:24] : 8'h00,
                     pstrb[2] ? pwdata[23:16] : 8'h00} & BCSR_ST_W1C;
      end
      stat_next = ((stat_reg & ~stat_clr) | stat_set) & BCSR_ST_W1C;
   end

   // status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= BCSR_ST_RESET;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // interrupt events mirror the status flags that are set this cycle
   assign irq_ev = {stat_set[BCSR_ST_DET_PERR],   stat_set[BCSR_ST_SIG_SERR],
                    stat_set[BCSR_ST_RCV_MABORT], stat_set[BCSR_ST_RCV_TABORT],
                    stat_set[BCSR_ST_SIG_TABORT], stat_set[BCSR_ST_MDPE]};
   assign irq_clr = (wr_done && hit_is && pstrb[0]) ? pwdata[5:0] : 6'h00;
   assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
   assign irq_mask_next = (wr_done && hit_im && pstrb[0]) ? pwdata[5:0] : irq_mask_reg;

   // sticky interrupt status and its mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= BCSR_IRQ_RESET;
         irq_mask_reg <= BCSR_IRQ_RESET;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // level interrupt from unmasked status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_next & irq_mask_next); // mask write moves irq with the mask
      end
   end

   // transaction gating toward the forwarding datapath
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_accept     <= 1'b0;
         mem_rd_accept <= 1'b0;
         fwd_accept    <= 1'b0;
         err_msg_send  <= 1'b0;
         inta_assert   <= 1'b0;
      end else begin
         io_accept     <= io_req && cmd_reg[BCSR_CMD_IO_EN];
         mem_rd_accept <= mem_rd_req && cmd_reg[BCSR_CMD_MEM_EN];
         fwd_accept    <= fwd_req && cmd_reg[BCSR_CMD_MASTER_EN];
         err_msg_send  <= err_send;
         inta_assert   <= intx_req && !cmd_reg[BCSR_CMD_INT_DIS];
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   io_gate_a: assert property (io_accept |-> $past(cmd_reg[BCSR_CMD_IO_EN]))
      else $error("io accepted while io space disabled");

   mem_gate_a: assert property (mem_rd_req && !cmd_reg[BCSR_CMD_MEM_EN] |=> !mem_rd_accept)
      else $error("memory read accepted while disabled");

   master_gate_a: assert property (fwd_req && cmd_reg[BCSR_CMD_MASTER_EN] |=> fwd_accept)
      else $error("forward not accepted while master enabled");

   ro_cmd_zero_a: assert property ((cmd_reg & ~BCSR_CMD_WMASK) == 16'h0000)
      else $error("read-only command bit became nonzero");

   mdpe_gate_a: assert property ($rose(stat_reg[BCSR_ST_MDPE]) |-> $past(cmd_reg[BCSR_CMD_PAR_RESP]))
      else $error("parity flag set with response disabled");

   serr_gate_a: assert property (err_msg_req && !cmd_reg[BCSR_CMD_SERR_EN]
                                 |=> !err_msg_send && !$rose(stat_reg[BCSR_ST_SIG_SERR]))
      else $error("error message sent while reporting disabled");

   inta_block_a: assert property (cmd_reg[BCSR_CMD_INT_DIS] ##1 cmd_reg[BCSR_CMD_INT_DIS] |-> !inta_assert)
      else $error("interrupt asserted while disabled");

   cap_read_a: assert property (pready && !pwrite && hit_cs |-> prdata[20] && !prdata[21]
                                && !prdata[23] && prdata[26:25] == 2'b00)
      else $error("constant status bits read wrong");

   abort_set_a: assert property (cpl_abort_tx |=> stat_reg[BCSR_ST_SIG_TABORT])
      else $error("signalled abort flag not set");

   rabort_set_a: assert property (cpl_abort_rx ##1 1'b1 |-> stat_reg[BCSR_ST_RCV_TABORT])
      else $error("received abort flag not set");

   ur_set_a: assert property (cpl_ur_rx |=> stat_reg[BCSR_ST_RCV_MABORT])
      else $error("unsupported request flag not set");

   serr_set_a: assert property (err_send |=> err_msg_send && stat_reg[BCSR_ST_SIG_SERR])
      else $error("signalled error flag not set");

   perr_set_a: assert property (poison_tlp_rx |=> stat_reg[BCSR_ST_DET_PERR])
      else $error("detected parity flag not set");

   flag_hold_a: assert property (stat_reg[BCSR_ST_DET_PERR] && !stat_clr[BCSR_ST_DET_PERR]
                                 |=> stat_reg[BCSR_ST_DET_PERR])
      else $error("flag lost without a one written");

   apb_wait_a: assert property (acc_phase && !pready |=> pready) // apb timing
      else $error("apb answer late");

   irq_level_a: assert property (|(irq_stat_reg & irq_mask_reg) |-> irq) // interrupt level
      else $error("interrupt low with unmasked status");

   // gating toward the datapath: io, memory and interrupt open, forward blocked
   io_open_a: assert property (io_req && cmd_reg[BCSR_CMD_IO_EN] |=> io_accept)
      else $error("io request dropped while io space enabled");

   mem_open_a: assert property (mem_rd_req && cmd_reg[BCSR_CMD_MEM_EN] |=> mem_rd_accept)
      else $error("memory read dropped while enabled");

   master_block_a: assert property (fwd_req && !cmd_reg[BCSR_CMD_MASTER_EN] |=> !fwd_accept)
      else $error("forward accepted while master disabled");

   inta_pass_a: assert property (intx_req && !cmd_reg[BCSR_CMD_INT_DIS] |=> inta_assert)
      else $error("interrupt dropped while enabled");

   // status flag setting and clearing
   mdpe_set_a: assert property (cmd_reg[BCSR_CMD_PAR_RESP] && (poison_cpl_rx || poison_wr_tx || parity_err)
                                |=> stat_reg[BCSR_ST_MDPE])
      else $error("parity flag not set with response enabled");

   cpl_poison_a: assert property (poison_cpl_rx |=> stat_reg[BCSR_ST_DET_PERR])
      else $error("poisoned completion not flagged");

   ro_stat_zero_a: assert property ((stat_reg & ~BCSR_ST_W1C) == 16'h0000)
      else $error("read-only status bit became nonzero");

   flag_clear_a: assert property (wr_done && hit_cs && pstrb[3] && pwdata[31] && !stat_set[BCSR_ST_DET_PERR]
                                  |=> !stat_reg[BCSR_ST_DET_PERR])
      else $error("flag not cleared by a one written");

   // command writes and read-only protection
   cmd_write_a: assert property (wr_done && hit_cs && pstrb[0]
                                 |=> cmd_reg[7:0] == ($past(pwdata[7:0]) & BCSR_CMD_WMASK[7:0]))
      else $error("command low byte not written as masked");

   cmd_hold_a: assert property (!(wr_done && hit_cs) |=> $stable(cmd_reg))
      else $error("command changed without a write");

   // apb answer and interrupt bookkeeping
   ready_pulse_a: assert property (pready |=> !pready) // apb timing
      else $error("apb ready held too long");

   slverr_map_a: assert property (pready |-> pslverr == !mapped) // unmapped word
      else $error("slave error does not match the decode");

   rd_unmapped_a: assert property (pready && !pwrite && !mapped |-> prdata == 32'h0000_0000) // unmapped word
      else $error("unmapped word read nonzero");

   irq_low_a: assert property (!(|(irq_stat_reg & irq_mask_reg)) |-> !irq) // interrupt level
      else $error("interrupt high with no unmasked status");

   irq_set_a: assert property (stat_set[BCSR_ST_SIG_TABORT] |=> irq_stat_reg[1]) // interrupt status
      else $error("interrupt status not set by its event");

   irq_clear_a: assert property (wr_done && hit_is && pstrb[0] && pwdata[1] && !irq_ev[1]
                                 |=> !irq_stat_reg[1]) // interrupt clear
      else $error("interrupt status not cleared by a one written");

   mask_write_a: assert property (wr_done && hit_im && pstrb[0]
                                  |=> irq_mask_reg == $past(pwdata[5:0])) // interrupt mask
      else $error("interrupt mask not written");

   cmd_write_c: cover property (wr_done && hit_cs && pstrb[0]);
   flag_clear_c: cover property (stat_reg[BCSR_ST_SIG_TABORT] ##1 !stat_reg[BCSR_ST_SIG_TABORT]);
   set_over_clear_c: cover property (stat_set[BCSR_ST_RCV_MABORT] && stat_clr[BCSR_ST_RCV_MABORT]);
   poison_resp_c: cover property (stat_set[BCSR_ST_MDPE]);
   irq_raise_c: cover property ($rose(irq));

endmodule

// *** src/bcsr_pkg.sv ***
// Purpose: constants for the bridge command and primary status registers
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   command sits in the low half and status in the high half of one word
package bcsr_pkg;

   // byte offsets of the register words
   localparam logic [11:0] BCSR_OFF_CMD_STAT  = 12'h004;
   localparam logic [11:0] BCSR_OFF_IRQ_STAT  = 12'h040;
   localparam logic [11:0] BCSR_OFF_IRQ_MASK  = 12'h044;

   // command field positions
   localparam int BCSR_CMD_IO_EN     = 0;
   localparam int BCSR_CMD_MEM_EN    = 1;
   localparam int BCSR_CMD_MASTER_EN = 2;
   localparam int BCSR_CMD_PAR_RESP  = 6;
   localparam int BCSR_CMD_SERR_EN   = 8;
   localparam int BCSR_CMD_INT_DIS   = 10;

   // writable command bits; all others read as zero
   localparam logic [15:0] BCSR_CMD_WMASK  = 16'h0547;
   localparam logic [15:0] BCSR_CMD_RESET  = 16'h0000;

   // status field positions, counted inside the high half
   localparam int BCSR_ST_CAP_LIST   = 4;
   localparam int BCSR_ST_MDPE       = 8;
   localparam int BCSR_ST_SIG_TABORT = 11;
   localparam int BCSR_ST_RCV_TABORT = 12;
   localparam int BCSR_ST_RCV_MABORT = 13;
   localparam int BCSR_ST_SIG_SERR   = 14;
   localparam int BCSR_ST_DET_PERR   = 15;

   // constant status bits and the write-one-to-clear flags
   localparam logic [15:0] BCSR_ST_CONST   = 16'h0010;
   localparam logic [15:0] BCSR_ST_W1C     = 16'hf900;
   localparam logic [15:0] BCSR_ST_RESET   = 16'h0000;

   // first capability pointer location
   localparam logic [7:0]  BCSR_CAP_PTR    = 8'h34;

   // interrupt status and mask: one bit per status flag
   localparam int          BCSR_IRQ_W      = 6;
   localparam logic [5:0]  BCSR_IRQ_RESET  = 6'h00;

endpackage

// *** dv/bcsr_rc_model.sv ***
// Purpose: apb master standing in for the configuration requester
// Assumes: one transfer at a time, called from the bench
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/100ps
module bcsr_rc_model (
   input  wire logic        pclk,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb
);
   // idle bus at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      pstrb   = 4'h0;
   end

   // one apb transfer: setup, access until pready, then release
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d; // flag clears carry ones only where meant
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule

// *** dv/tb_bridge_command_status_regs.sv ***
// Purpose: self-checking bench for the command and status register block
// Assumes: apb answers arrive with pready; events are one-cycle pulses
// Notes:   read expectations are queued and compared by a monitor
`timescale 1ns/100ps
module tb_bridge_command_status_regs;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [8:0]  ev = 9'h0;
   logic [2:0]  rq = 3'h0;
   logic        io_accept, mem_rd_accept, fwd_accept, err_msg_send, inta_assert, irq;
   logic [64:0] exp_q[$];
   logic [64:0] note;
   logic [15:0] st = 16'h0;
   logic [15:0] c;
   logic [31:0] d;
   int          miscompares = 0;
   int          checks_done = 0;
   int          seed = 11;
   int          ev_i[6] = '{1, 3, 4, 5, 6, 7};
   int          st_b[6] = '{8, 15, 11, 12, 13, 14};

   bcsr_rc_model rc_i (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
                       .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   bcsr_regs bcsr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .io_req(rq[0]), .mem_rd_req(rq[1]), .fwd_req(rq[2]), .poison_cpl_rx(ev[0]), .poison_wr_tx(ev[1]),
      .parity_err(ev[2]), .poison_tlp_rx(ev[3]), .cpl_abort_tx(ev[4]), .cpl_abort_rx(ev[5]),
      .cpl_ur_rx(ev[6]), .err_msg_req(ev[7]), .intx_req(ev[8]), .io_accept(io_accept),
      .mem_rd_accept(mem_rd_accept), .fwd_accept(fwd_accept), .err_msg_send(err_msg_send),
      .inta_assert(inta_assert), .irq(irq));

   // clock
   always #4 pclk = ~pclk;

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
      exp_q.push_back({err, 32'hffffffff, e});
      rc_i.xfer(1'b0, a, 32'h0, 4'h0);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, input logic err);
      exp_q.push_back({err, 32'h0, 32'h0});
      rc_i.xfer(1'b1, a, v, s);
   endtask

   // one event pulse, outputs checked after the registering edge
   task automatic pulse(input logic [8:0] m, input logic [2:0] r);
      @(posedge pclk);
      ev <= m;
      rq <= r;
      @(posedge pclk);
      ev <= 9'h0;
      rq <= 3'h0;
      #1;
   endtask

   task automatic test_done;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // monitor: compare each completed transfer with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("[ERR] %0t transfer with no expected result", $time);
         end
         note = (exp_q.size() > 0) ? exp_q.pop_front() : 65'h0;
         chk(prdata & note[63:32], note[31:0] & note[63:32]);
         chk({31'h0, pslverr}, {31'h0, note[64]});
      end
   end

   // watchdog
   initial begin
      #100us;
      miscompares++;
      test_done();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'h00100000, 1'b0);
      rd(12'h040, 32'h0, 1'b0);
      rd(12'h044, 32'h0, 1'b0);
      // random command words, then gated requests
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         c = d[15:0] & 16'h0547;
         wr(12'h004, d, 4'b0011, 1'b0);
         rd(12'h004, {st | 16'h0010, c}, 1'b0);
         pulse(9'h180, 3'h7);
         chk({io_accept, mem_rd_accept, fwd_accept, err_msg_send, inta_assert},
             {c[0], c[1], c[2], c[8], ~c[10]});
         if (c[8]) st[14] = 1'b1;
      end
      // clear all flags, then parity faults without response enable
      wr(12'h004, 32'hffff0000, 4'hf, 1'b0);
      st = 16'h0;
      pulse(9'h087, 3'h0);
      rd(12'h004, 32'h80100000, 1'b0);
      st = 16'h8000;
      c = 16'h0147;
      wr(12'h004, {16'h0, c}, 4'h3, 1'b0);
      for (int i = 0; i < 6; i++) begin
         pulse(9'h1 << ev_i[i], 3'h0);
         st[st_b[i]] = 1'b1;
         rd(12'h004, {st | 16'h0010, c}, 1'b0);
      end
      // zeros leave flags, a single one clears only its flag
      wr(12'h004, {16'h0, c}, 4'hf, 1'b0);
      rd(12'h004, {st | 16'h0010, c}, 1'b0);
      wr(12'h004, {16'h0800, c}, 4'hf, 1'b0);
      st[11] = 1'b0;
      rd(12'h004, {st | 16'h0010, c}, 1'b0);
      // interrupt masked, unmasked, cleared
      chk({31'h0, irq}, 32'h0);
      wr(12'h044, 32'h3f, 4'h1, 1'b0);
      repeat (2) @(posedge pclk);
      #1 chk({31'h0, irq}, 32'h1);
      rd(12'h044, 32'h3f, 1'b0);
      rd(12'h040, 32'h3f, 1'b0);
      wr(12'h040, 32'h3f, 4'h1, 1'b0);
      repeat (2) @(posedge pclk);
      #1 chk({31'h0, irq}, 32'h0);
      rd(12'h040, 32'h0, 1'b0);
      // parity fault, then poisoned completion, with response enabled
      wr(12'h004, {16'hffff, c}, 4'hf, 1'b0);
      pulse(9'h004, 3'h0);
      rd(12'h004, {16'h0110, c}, 1'b0);
      wr(12'h004, {16'hffff, c}, 4'hf, 1'b0);
      pulse(9'h001, 3'h0);
      rd(12'h004, {16'h8110, c}, 1'b0);
      st = 16'h8100;
      // unmapped word
      wr(12'h008, 32'hffffffff, 4'hf, 1'b1);
      rd(12'h008, 32'h0, 1'b1);
      rd(12'h004, {st | 16'h0010, c}, 1'b0);
      // reset in mid-run returns every register to zero
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'h00100000, 1'b0);
      rd(12'h040, 32'h0, 1'b0);
      rd(12'h044, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      test_done();
   end
endmodule
